// file: inc/tw_defs.svh
// constants for the two-wire serial memory target
`ifndef TW_DEFS_SVH
`define TW_DEFS_SVH

// ==========================================================
// device address word
`define TW_DEV_CODE 4'hA
`define TW_BIT_ACK 4'h8
`define TW_BIT_END 4'h9

// ==========================================================
// memory size codes and geometry
`define TW_SIZE_1K 3'h0
`define TW_SIZE_2K 3'h1
`define TW_SIZE_4K 3'h2
`define TW_SIZE_8K 3'h3
`define TW_SIZE_16K 3'h4
`define TW_ADDR_W 11
`define TW_MEM_DEPTH 2048
`define TW_AMASK_1K 11'h07F
`define TW_AMASK_2K 11'h0FF
`define TW_AMASK_4K 11'h1FF
`define TW_AMASK_8K 11'h3FF
`define TW_AMASK_16K 11'h7FF
`define TW_PMASK_SMALL 11'h007
`define TW_PMASK_LARGE 11'h00F

// ==========================================================
// self-timed write cycle
`define TW_T_WR_MS 5
`define TW_CLK_KHZ 10000
`define TW_WR_CYCLES (`TW_T_WR_MS * `TW_CLK_KHZ)
`define TW_WR_CNT_W 20

`endif

// file: inc/tw_pkg.sv
// types shared by the two-wire serial memory target
package tw_pkg;

    // protocol state of the target
    typedef enum logic [2:0] {
        TW_IDLE = 3'h0,
        TW_DEV = 3'h1,
        TW_WADR = 3'h2,
        TW_WDAT = 3'h3,
        TW_RDAT = 3'h4,
        TW_BUSY = 3'h5
    } tw_state_t;

endpackage

// file: inc/tw_mem_if.sv
// carrier between the protocol logic and the byte array
`timescale 1ns/100ps
`default_nettype none
`include "tw_defs.svh"

interface tw_mem_if;
    logic we;
    logic [`TW_ADDR_W-1:0] waddr;
    logic [`TW_ADDR_W-1:0] raddr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport ctrl (output we, output waddr, output wdata, output raddr,
                  input rdata);
    modport mem (input we, input waddr, input wdata, input raddr,
                 output rdata);
endinterface

`default_nettype wire

// file: design/tw_mem.sv
// byte array with one write port and a registered read port
`timescale 1ns/100ps
`default_nettype none
`include "tw_defs.svh"

module tw_mem (
    input wire logic sys_clk,
    tw_mem_if.mem bus
);
    logic [7:0] cells [0:`TW_MEM_DEPTH-1];

    // ==========================================================
    // storage; contents are undefined until written, no reset
    always_ff @(posedge sys_clk) begin
        if (bus.we) begin
            cells[bus.waddr] <= bus.wdata;
        end
        bus.rdata <= cells[bus.raddr];
    end
endmodule // tw_mem

`default_nettype wire

// file: design/tw_target.sv
// two-wire serial memory target: addressing, writes, reads, write cycle
//
// Summary of operation
// - every start is followed by an 8-bit device address word
// - upper four address bits must be the fixed 1010 pattern
// - two smallest sizes compare three select bits with the pins
// - middle size compares two upper select bits; third is a page bit
// - second-largest size compares top select bit; next two are page bits
// - largest size uses all three as page bits, top of word address
// - eighth address bit high selects read, low selects write
// - match gives zero acknowledge; mismatch idles until next start
// - byte write: word address then data, each acknowledged, then stop
// - stop after write starts self-timed cycle; bus ignored meanwhile
// - page write holds 8 bytes small sizes, 16 bytes larger ones
// - further bytes in a page write are each acknowledged until stop
// - writes step only low page bits, wrapping within the page
// - address polls are acknowledged only after the write completes
// - address counter holds last accessed plus one between operations
// - reads wrap at memory end, writes wrap within the page
// - current read shifts out byte at counter; controller nacks, stops
// - random read: dummy write of address, fresh start, read select
// - ninth clock of each read byte advances read address; controller ack sends next byte
// - write cycle is timed from the ending stop
// - falling data with clock high is a start
// - rising data with clock high is a stop; device returns to standby
// - device drives data low during ninth clock for received words
// - data driven only changes while clock is low
`timescale 1ns/100ps
`default_nettype none
`include "tw_defs.svh"

module tw_target #(
    parameter logic [2:0] MEM_SIZE = `TW_SIZE_16K,
    parameter int WR_CYCLES = `TW_WR_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic scl,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic chip_select_pin_two,
    input wire logic chip_select_pin_one,
    input wire logic chip_select_pin_zero,
    output logic write_busy
);
    // ==========================================================
    // size dependent geometry
    // size parameter shapes masks
    function automatic logic [10:0] amask_of(input logic [2:0] sz);
        case (sz)
            `TW_SIZE_1K: return `TW_AMASK_1K;
            `TW_SIZE_2K: return `TW_AMASK_2K;
            `TW_SIZE_4K: return `TW_AMASK_4K;
            `TW_SIZE_8K: return `TW_AMASK_8K;
            default: return `TW_AMASK_16K;
        endcase
    endfunction

    function automatic logic [10:0] pmask_of(input logic [2:0] sz);
        if (sz == `TW_SIZE_1K || sz == `TW_SIZE_2K) begin
            return `TW_PMASK_SMALL;
        end
        return `TW_PMASK_LARGE;
    endfunction

    localparam logic [10:0] AMASK = amask_of(MEM_SIZE);
    localparam logic [10:0] PMASK = pmask_of(MEM_SIZE);
    localparam logic [`TW_WR_CNT_W-1:0] WR_LOAD =
        `TW_WR_CNT_W'(WR_CYCLES - 1);

    // fixed pattern, then per-size select compare
    function automatic logic dev_match(input logic [7:0] w,
                                       input logic [2:0] pins);
        if (w[7:4] != `TW_DEV_CODE) begin
            return 1'b0;
        end
        case (MEM_SIZE)
            `TW_SIZE_1K, `TW_SIZE_2K: return w[3:1] == pins;
            `TW_SIZE_4K: return w[3:2] == pins[2:1];
            `TW_SIZE_8K: return w[3] == pins[2];
            default: return 1'b1;
        endcase
    endfunction

    // select positions not compared become page bits
    function automatic logic [2:0] page_of(input logic [7:0] w);
        case (MEM_SIZE)
            `TW_SIZE_4K: return {2'h0, w[1]};
            `TW_SIZE_8K: return {1'h0, w[2:1]};
            `TW_SIZE_16K: return w[3:1];
            default: return 3'h0;
        endcase
    endfunction

    // step low bits only, keep the page row
    function automatic logic [10:0] wr_next(input logic [10:0] a);
        return (a & ~PMASK) | ((a + 11'h001) & PMASK);
    endfunction

    // read wraps from the last byte to the first
    function automatic logic [10:0] rd_next(input logic [10:0] a);
        return (a + 11'h001) & AMASK;
    endfunction

    // ==========================================================
    // pin synchronisers: [0] is read only by [1]
    logic [2:0] scl_sync;
    logic [2:0] sda_sync;
    logic [2:0] cs_meta;
    logic [2:0] cs_pin;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            scl_sync <= 3'h7;
            sda_sync <= 3'h7;
            cs_meta <= 3'h0;
            cs_pin <= 3'h0;
        end else begin
            scl_sync <= {scl_sync[1], scl_sync[0], scl};
            sda_sync <= {sda_sync[1], sda_sync[0], sda_i};
            cs_meta <= {chip_select_pin_two, chip_select_pin_one,
                        chip_select_pin_zero};
            cs_pin <= cs_meta;
        end
    end

    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic sda_in;

    // bus events from the synchronised levels
    assign scl_rise = scl_sync[1] & ~scl_sync[2];
    assign scl_fall = ~scl_sync[1] & scl_sync[2];
    assign sda_in = sda_sync[1];
    // start is data falling under a high clock
    assign start_det = scl_sync[1] & scl_sync[2] & sda_sync[2] & ~sda_in;
    // stop is data rising under a high clock
    assign stop_det = scl_sync[1] & scl_sync[2] & ~sda_sync[2] & sda_in;

    tw_pkg::tw_state_t state;
    tw_pkg::tw_state_t next_state;
    logic [3:0] bit_cnt;
    logic [7:0] rx;
    logic [7:0] tx;
    logic [10:0] addr;
    logic [2:0] page;
    logic rw;
    logic mack;
    logic wrote;
    logic [`TW_WR_CNT_W-1:0] wr_cnt;
    logic ack_slot;
    logic end_slot;
    logic match;

    assign ack_slot = scl_fall && (bit_cnt == `TW_BIT_ACK);
    assign end_slot = scl_fall && (bit_cnt == `TW_BIT_END);
    assign match = dev_match(rx, cs_pin);

    tw_mem_if mem_bus ();

    tw_mem u_mem (
        .sys_clk(sys_clk),
        .bus(mem_bus)
    );

    assign mem_bus.raddr = addr;

    // ==========================================================
    // bit counter, receive shifter, controller acknowledge
    // eight bits then the ninth acknowledge clock
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            bit_cnt <= 4'h0;
            rx <= 8'h00;
            mack <= 1'b0;
        end else if (start_det || stop_det) begin
            bit_cnt <= 4'h0;
        end else if (scl_rise && bit_cnt < `TW_BIT_END) begin
            bit_cnt <= bit_cnt + 4'h1;
            if (bit_cnt < `TW_BIT_ACK) begin
                rx <= {rx[6:0], sda_in};
            end else begin
                mack <= ~sda_in;
            end
        end else if (end_slot) begin
            bit_cnt <= 4'h0;
        end
    end

    // ==========================================================
    // protocol state; a running write cycle hides every bus event
    always_comb begin
        next_state = state;
        if (state == tw_pkg::TW_BUSY) begin // polls go unanswered
            if (wr_cnt == `TW_WR_CNT_W'(0)) begin
                next_state = tw_pkg::TW_IDLE;
            end
        end else if (start_det) begin
            next_state = tw_pkg::TW_DEV;
        end else if (stop_det) begin
            // stop after written bytes opens the write cycle
            next_state = wrote ? tw_pkg::TW_BUSY : tw_pkg::TW_IDLE;
        end else if (ack_slot) begin
            // no match means standby until the next start
            if (state == tw_pkg::TW_DEV && !match) begin
                next_state = tw_pkg::TW_IDLE;
            end
        end else if (end_slot) begin
            case (state)
                // operation select bit picks the direction
                tw_pkg::TW_DEV: next_state = rw ? tw_pkg::TW_RDAT
                                                : tw_pkg::TW_WADR;
                tw_pkg::TW_WADR: next_state = tw_pkg::TW_WDAT;
                tw_pkg::TW_RDAT: if (!mack) begin
                    next_state = tw_pkg::TW_IDLE;
                end
                default: next_state = state;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= tw_pkg::TW_IDLE;
            write_busy <= 1'b0;
        end else begin
            state <= next_state;
            write_busy <= (next_state == tw_pkg::TW_BUSY);
        end
    end

    // ==========================================================
    // write cycle timer and pending-write flag
    // time runs from the ending stop
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_cnt <= `TW_WR_CNT_W'(0);
            wrote <= 1'b0;
        end else if (state != tw_pkg::TW_BUSY && stop_det && wrote) begin
            wr_cnt <= WR_LOAD;
            wrote <= 1'b0;
        end else begin
            if (wr_cnt != `TW_WR_CNT_W'(0)) begin
                wr_cnt <= wr_cnt - `TW_WR_CNT_W'(1);
            end
            // a repeated start drops a pending write cycle
            if (state != tw_pkg::TW_BUSY && (start_det || stop_det)) begin
                wrote <= 1'b0;
            end else if (ack_slot && state == tw_pkg::TW_WDAT) begin
                wrote <= 1'b1;
            end
        end
    end

    // ==========================================================
    // address counter and array writes; counter kept across operations
    // counter points one past the last access between operations
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            addr <= 11'h000;
            page <= 3'h0;
            rw <= 1'b0;
            mem_bus.we <= 1'b0;
            mem_bus.waddr <= 11'h000;
            mem_bus.wdata <= 8'h00;
        end else begin
            mem_bus.we <= 1'b0;
            if (ack_slot) begin
                case (state)
                    tw_pkg::TW_DEV: if (match) begin
                        rw <= rx[0];
                        page <= page_of(rx);
                    end
                    // word address load serves random reads too
                    tw_pkg::TW_WADR: addr <= {page, rx} & AMASK;
                    // every page byte stored, then address steps
                    tw_pkg::TW_WDAT: begin
                        mem_bus.we <= 1'b1;
                        mem_bus.waddr <= addr;
                        mem_bus.wdata <= rx;
                        addr <= wr_next(addr);
                    end
                    default: addr <= addr;
                endcase
            end else if (scl_rise && bit_cnt == `TW_BIT_ACK &&
                         state == tw_pkg::TW_RDAT) begin
                // advance at the ninth clock, read data settles
                addr <= rd_next(addr);
            end
        end
    end

    // ==========================================================
    // data line drive; open drain, so only a low is ever driven
    // drive changes follow a clock fall only
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sda_oe <= 1'b0;
            sda_o <= 1'b0;
            tx <= 8'h00;
        end else if (start_det || stop_det) begin
            sda_oe <= 1'b0;
        end else if (ack_slot) begin
            // pull low through the ninth clock
            sda_oe <= (state == tw_pkg::TW_DEV && match) ||
                      state == tw_pkg::TW_WADR || state == tw_pkg::TW_WDAT;
        end else if (end_slot) begin
            // first read byte comes from the counter
            if ((state == tw_pkg::TW_DEV && rw) ||
                (state == tw_pkg::TW_RDAT && mack)) begin
                tx <= {mem_bus.rdata[6:0], 1'b0};
                sda_oe <= ~mem_bus.rdata[7];
            end else begin
                sda_oe <= 1'b0;
            end
        end else if (scl_fall && state == tw_pkg::TW_RDAT &&
                     bit_cnt != 4'h0) begin
            sda_oe <= ~tx[7];
            tx <= {tx[6:0], 1'b0};
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);

    sequence s_ack_held;
        sda_oe [*3];
    endsequence

    a_match_ack: assert property (
        ack_slot && state == tw_pkg::TW_DEV && match |=> s_ack_held)
        else $error("matching address not acknowledged");
    a_mismatch_idle: assert property (
        ack_slot && state == tw_pkg::TW_DEV && !match |=>
        state == tw_pkg::TW_IDLE && !sda_oe)
        else $error("mismatched address not ignored");
    a_write_ack: assert property (
        ack_slot && (state == tw_pkg::TW_WADR ||
                     state == tw_pkg::TW_WDAT) |=> s_ack_held)
        else $error("write byte not acknowledged");
    a_busy_entry: assert property (
        state != tw_pkg::TW_BUSY && stop_det && wrote |=>
        state == tw_pkg::TW_BUSY && wr_cnt == WR_LOAD && write_busy)
        else $error("write cycle did not start at stop");
    a_busy_quiet: assert property (
        state == tw_pkg::TW_BUSY |-> !sda_oe ##1
        state != tw_pkg::TW_DEV)
        else $error("target answered during write cycle");
    a_busy_end: assert property (
        state == tw_pkg::TW_BUSY && wr_cnt == `TW_WR_CNT_W'(0) |=>
        state == tw_pkg::TW_IDLE && !write_busy)
        else $error("write cycle did not end on time");
    a_page_wrap: assert property (
        ack_slot && state == tw_pkg::TW_WDAT |=>
        addr == wr_next($past(addr)) && mem_bus.we &&
        mem_bus.waddr == $past(addr))
        else $error("write address step wrong");
    a_read_step: assert property (
        scl_rise && bit_cnt == `TW_BIT_ACK && state == tw_pkg::TW_RDAT
        && !start_det && !stop_det |=> addr == rd_next($past(addr)))
        else $error("read address step wrong");
    a_start_dev: assert property (
        start_det && state != tw_pkg::TW_BUSY |=>
        state == tw_pkg::TW_DEV && bit_cnt == 4'h0 && !sda_oe)
        else $error("start not taken");
    a_stop_idle: assert property (
        stop_det && state != tw_pkg::TW_BUSY && !wrote |=>
        state == tw_pkg::TW_IDLE && !sda_oe)
        else $error("stop did not return to standby");
    a_drive_low: assert property (
        $changed(sda_oe) && !$past(start_det) && !$past(stop_det) |->
        !$past(scl_sync[1]))
        else $error("data drive changed with clock high");
endmodule // tw_target

`default_nettype wire

// file: tb/tw_ctl_model.sv
// bus controller model: drives the bus clock, shares the data line
`timescale 1ns/100ps
`default_nettype none

module tw_ctl_model (
    input wire logic sys_clk,
    input wire logic sda,
    output logic scl,
    output logic sda_low
);
    // ==========================================================
    // bit level
    // idle bus: clock high, data released to the pull-up
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    // four cycles low, four high: an 800 ns bus clock; the target's
    // answer lands about 3 cycles after the fall, well before sampling
    // data moves in low phase
    task automatic bit_cycle(input logic b, output logic r);
        @(negedge sys_clk) scl = 1'b0;
        repeat (2) @(negedge sys_clk);
        sda_low = ~b;
        repeat (2) @(negedge sys_clk);
        scl = 1'b1;
        repeat (3) @(negedge sys_clk);
        r = sda;
    endtask

    // ==========================================================
    // framing
    // data falls while clock high
    task automatic start_cond();
        logic r;
        bit_cycle(1'b1, r);
        sda_low = 1'b1;
        repeat (4) @(negedge sys_clk);
    endtask

    // data rises while clock high; clock then stands high
    task automatic stop_cond();
        logic r;
        bit_cycle(1'b0, r);
        sda_low = 1'b0;
        repeat (4) @(negedge sys_clk);
    endtask

    // ==========================================================
    // bytes
    // msb first, ninth clock reads acknowledge
    task automatic send_byte(input logic [7:0] d, output logic nack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(d[i], r);
        end
        bit_cycle(1'b1, nack);
    endtask

    // controller acks to go on, withholds to end
    task automatic recv_byte(input logic more, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(1'b1, r);
            d[i] = r;
        end
        bit_cycle(~more, r);
    endtask
endmodule // tw_ctl_model

`default_nettype wire

// file: tb/two_wire_eeprom_target_access_bench.sv
// self-checking bench for the two-wire serial memory target
`timescale 1ns/100ps
`default_nettype none
`include "tw_defs.svh"

module two_wire_eeprom_target_access_bench;
    localparam int WR_CYC = 200;
    localparam int TIMEOUT = 20000;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic sda;
    logic scl;
    logic sda_low;
    logic sda_o;
    logic sda_oe;
    logic write_busy;
    logic o_s;
    logic oe_s;
    logic busy_s;
    int fail_count = 0;
    int n_compared = 0;
    int cycles = 0;
    logic [7:0] exp_mem [512];

    // ==========================================================
    // clock, bus wiring, instances
    always #50 sys_clk = ~sys_clk;

    // open drain with pull-up: low whenever any of the three drivers pulls
    assign sda = (sda_low || (sda_oe && !sda_o) || (oe_s && !o_s)) ?
                 1'b0 : 1'b1;

    tw_ctl_model m (.sys_clk(sys_clk), .sda(sda), .scl(scl),
                    .sda_low(sda_low));

    // mid size: two select pins compared, one page bit, 16-byte page
    tw_target #(.MEM_SIZE(`TW_SIZE_4K), .WR_CYCLES(WR_CYC)) uut (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .scl(scl),
        .sda_i(sda),
        .sda_o(sda_o),
        .sda_oe(sda_oe),
        .chip_select_pin_two(1'b1),
        .chip_select_pin_one(1'b0),
        .chip_select_pin_zero(1'b1),
        .write_busy(write_busy)
    );

    // smallest size strapped 0,1,1: all three pins compared, 8-byte page
    tw_target #(.MEM_SIZE(`TW_SIZE_1K), .WR_CYCLES(WR_CYC)) uut_small (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .scl(scl),
        .sda_i(sda),
        .sda_o(o_s),
        .sda_oe(oe_s),
        .chip_select_pin_two(1'b0),
        .chip_select_pin_one(1'b1),
        .chip_select_pin_zero(1'b1),
        .write_busy(busy_s)
    );

    // ==========================================================
    // checking helpers
    task automatic chk_bit(input logic got, input logic exp,
                           input string what);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t %s got %b want %b", $time, what, got, exp);
        end
    endtask

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp,
                            input string what);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t %s got %h want %h", $time, what, got, exp);
        end
    endtask

    // select bits follow the strapped pins two=1, one=0
    function automatic logic [7:0] dev(input logic pg, input logic rd);
        return {`TW_DEV_CODE, 1'b1, 1'b0, pg, rd};
    endfunction

    // bounded wait for the write cycle to finish
    task automatic wait_idle(input int lim);
        int n;
        n = 0;
        while (write_busy !== 1'b0 && n < lim) begin
            @(negedge sys_clk);
            n++;
        end
        chk_bit(write_busy, 1'b0, "write cycle end");
    endtask

    // ==========================================================
    // scenarios
    // wrong code, wrong pin one, wrong pin two; bus then ignored
    task automatic t_addr_refuse();
        logic nk;
        logic [7:0] bad [3];
        bad = '{8'hB4, {`TW_DEV_CODE, 4'hC}, {`TW_DEV_CODE, 4'h0}};
        for (int i = 0; i < 3; i++) begin
            m.start_cond();
            m.send_byte(bad[i], nk);
            chk_bit(nk, 1'b1, "mismatch nack");
            m.send_byte(8'h00, nk);
            chk_bit(nk, 1'b1, "ignored after mismatch");
            m.stop_cond();
        end
    endtask

    task automatic t_byte_write();
        logic nk;
        m.start_cond();
        m.send_byte(dev(1'b0, 1'b0), nk);
        chk_bit(nk, 1'b0, "dev ack, unused pin ignored");
        m.send_byte(8'h00, nk);
        chk_bit(nk, 1'b0, "word ack");
        m.send_byte(8'h5A, nk);
        chk_bit(nk, 1'b0, "data ack");
        m.stop_cond();
        exp_mem[0] = 8'h5A;
        repeat (4) @(negedge sys_clk);
        chk_bit(write_busy, 1'b1, "busy after stop");
        wait_idle(WR_CYC + 20);
    endtask

    // 18 bytes from 0x1F8 roll over inside the page, poll while busy
    task automatic t_page_write();
        logic nk;
        int t0;
        m.start_cond();
        m.send_byte(dev(1'b1, 1'b0), nk);
        chk_bit(nk, 1'b0, "dev ack page bit");
        m.send_byte(8'hF8, nk);
        chk_bit(nk, 1'b0, "word ack");
        for (int i = 0; i < 18; i++) begin
            m.send_byte(8'h40 + 8'(i), nk);
            chk_bit(nk, 1'b0, "page byte ack");
            exp_mem[9'h1F0 | 9'((8 + i) & 15)] = 8'h40 + 8'(i);
        end
        m.stop_cond();
        t0 = cycles;
        m.start_cond();
        m.send_byte(dev(1'b1, 1'b0), nk);
        chk_bit(nk, 1'b1, "poll refused while busy");
        m.stop_cond();
        while (cycles - t0 < 190) begin
            @(negedge sys_clk);
        end
        chk_bit(write_busy, 1'b1, "busy lasts the write time");
        wait_idle(25);
    endtask

    // dummy write, repeated start, whole page read back
    task automatic t_rand_read();
        logic nk;
        logic [7:0] d;
        m.start_cond();
        m.send_byte(dev(1'b1, 1'b0), nk);
        chk_bit(nk, 1'b0, "poll ack after write");
        m.send_byte(8'hF0, nk);
        chk_bit(nk, 1'b0, "word ack");
        m.start_cond();
        m.send_byte(dev(1'b1, 1'b1), nk);
        chk_bit(nk, 1'b0, "read select ack");
        for (int i = 0; i < 16; i++) begin
            m.recv_byte(i < 15, d);
            chk_byte(d, exp_mem[9'h1F0 + 9'(i)], "seq read");
        end
        m.stop_cond();
    endtask

    // counter wrapped from the top of memory, so it reads from zero
    task automatic t_cur_read();
        logic nk;
        logic [7:0] d;
        m.start_cond();
        m.send_byte(dev(1'b0, 1'b1), nk);
        chk_bit(nk, 1'b0, "current read ack");
        m.recv_byte(1'b0, d);
        chk_byte(d, exp_mem[0], "read wrap to zero");
        m.stop_cond();
        chk_bit(sda_oe, 1'b0, "released after stop");
    endtask

    // smallest size: top word-address bit masked, nine bytes wrap an
    // 8-byte page so the first one is overwritten
    task automatic t_small_page();
        logic nk;
        logic [7:0] d;
        logic [7:0] e [8];
        m.start_cond();
        m.send_byte(8'hA6, nk);
        chk_bit(nk, 1'b0, "small dev ack");
        m.send_byte(8'h8E, nk);
        chk_bit(nk, 1'b0, "small word ack");
        for (int i = 0; i < 9; i++) begin
            m.send_byte(8'h60 + 8'(i), nk);
            chk_bit(nk, 1'b0, "small page ack");
            e[(6 + i) & 7] = 8'h60 + 8'(i);
        end
        m.stop_cond();
        repeat (4) @(negedge sys_clk);
        chk_bit(busy_s, 1'b1, "small busy");
        repeat (WR_CYC + 4) @(negedge sys_clk);
        chk_bit(busy_s, 1'b0, "small busy end");
        m.start_cond();
        m.send_byte(8'hA6, nk);
        chk_bit(nk, 1'b0, "small poll ack");
        m.send_byte(8'h08, nk);
        chk_bit(nk, 1'b0, "small word ack");
        m.start_cond();
        m.send_byte(8'hA7, nk);
        chk_bit(nk, 1'b0, "small read ack");
        for (int i = 0; i < 8; i++) begin
            m.recv_byte(i < 7, d);
            chk_byte(d, e[i], "small page wrap");
        end
        m.stop_cond();
    endtask

    // ==========================================================
    // verdict and watchdog
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // a hang is cut short and reported as a mismatch
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == TIMEOUT) begin
            fail_count++;
            $display("BAD t=%0t run did not finish", $time);
            conclude();
        end
    end

    initial begin
        repeat (5) @(negedge sys_clk);
        rst_b = 1'b1;
        repeat (4) @(negedge sys_clk);
        chk_bit(sda_oe, 1'b0, "idle after reset");
        chk_bit(write_busy, 1'b0, "not busy after reset");
        chk_bit(sda_o, 1'b0, "open drain drives low only");
        t_addr_refuse();
        t_byte_write();
        t_page_write();
        t_rand_read();
        t_cur_read();
        t_small_page();
        conclude();
    end
endmodule // two_wire_eeprom_target_access_bench

`default_nettype wire
